// File: design/dlr_defines.svh
// timing constants and line-state codes for the lane and reset sequencer
`ifndef DLR_DEFINES_SVH
`define DLR_DEFINES_SVH
`define DLR_REF_NS 25
`define DLR_LPX_NS 50
`define DLR_LP_CYC ((`DLR_LPX_NS + `DLR_REF_NS - 1) / `DLR_REF_NS)
`define DLR_SURE_CYC (`DLR_LP_CYC + 1)
`define DLR_GET_PER 5
`define DLR_GET_CYC (`DLR_GET_PER * `DLR_LP_CYC)
`define DLR_SKIP_NS 40
`define DLR_SKIP_CYC ((`DLR_SKIP_NS + `DLR_REF_NS - 1) / `DLR_REF_NS)
`define DLR_REJ_US 5
`define DLR_FULL_US 10
`define DLR_REJ_CYC (`DLR_REJ_US * 1000 / `DLR_REF_NS)
`define DLR_FULL_CYC (`DLR_FULL_US * 1000 / `DLR_REF_NS)
`define DLR_OTP_MS 5
`define DLR_BLANK_MS 120
`define DLR_MS_CYC(ms) ((ms) * 1000000 / `DLR_REF_NS)
`define DLR_AGE_MAX 4'hF
`define DLR_LP00 2'h0
`define DLR_LP01 2'h1
`define DLR_LP10 2'h2
`define DLR_LP11 2'h3
`endif

// File: design/dlr_pkg.sv
// types for the lane and reset sequencer
`default_nettype none
package dlr_pkg;
	typedef struct packed {
		logic p;
		logic n;
	} dlr_lp_t;
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} dlr_byte_t;
	typedef enum logic [3:0] {
		LN_STOP = 4'h0, LN_RQST = 4'h1, LN_HS = 4'h2, LN_SKIP = 4'h3,
		LN_BTA1 = 4'h4, LN_BTA2 = 4'h5, LN_BTA3 = 4'h6, LN_SURE = 4'h7,
		LN_GET = 4'h8, LN_OWN = 4'h9, LN_BK10 = 4'hA, LN_BK00 = 4'hB
	} dlr_lane_t;
	typedef enum logic [1:0] {
		CK_STOP = 2'h0, CK_RQST = 2'h1, CK_HS = 2'h2
	} dlr_ck_t;
	typedef enum logic [1:0] {
		RS_RUN = 2'h0, RS_LOW = 2'h1, RS_OTP = 2'h2, RS_BLANK = 2'h3
	} dlr_rs_t;
	typedef struct packed {
		dlr_lp_t     d0_m;
		dlr_lp_t     d0_s;
		dlr_lp_t     d0_q;
		dlr_lp_t     ck_m;
		dlr_lp_t     ck_s;
		dlr_lp_t     ck_q;
		logic        rst_m;
		logic        rst_s;
		dlr_lane_t   lane;
		dlr_ck_t     ck;
		dlr_rs_t     rs;
		logic [3:0]  age;
		logic [3:0]  lcnt;
		logic [22:0] rcnt;
		logic [8:0]  hcnt;
		logic        asleep;
		logic        full;
		logic        lp_err;
		logic        hs_open;
	} dlr_ref_t;
	typedef struct packed {
		logic      acc_m;
		logic      acc_s;
		dlr_byte_t rx;
	} dlr_link_t;
endpackage
`default_nettype wire

// File: design/dlr_top.sv
// lane state sequencing, turnaround and reset-pin handling of the display input
`default_nettype none
`include "dlr_defines.svh"
module dlr_top #(
	parameter int OTP_CYC   = `DLR_MS_CYC(`DLR_OTP_MS),
	parameter int BLANK_CYC = `DLR_MS_CYC(`DLR_BLANK_MS)
) (
	// clocks and reset
	input  wire logic               REF_CLK,
	input  wire logic               RESET,
	input  wire logic               LINK_CLK,
	// reset pin and sleep state
	input  wire logic               RESET_PIN_N,
	input  wire logic               SLEEP_IN,
	// data lane 0 low-power lines
	input  wire dlr_pkg::dlr_lp_t   D0_LP,
	output logic                    D0_LP_OE,
	output dlr_pkg::dlr_lp_t        D0_LP_OUT,
	output logic                    D0_TERM,
	output logic                    LP_ERR,
	// clock lane low-power lines
	input  wire dlr_pkg::dlr_lp_t   CLK_LP,
	output logic                    CLK_TERM,
	// high-speed bytes on the link clock
	input  wire dlr_pkg::dlr_byte_t HS_IN,
	output dlr_pkg::dlr_byte_t      RX_OUT,
	// reset sequence status
	output logic                    CHIP_RESET,
	output logic                    RESET_FULL,
	output logic                    OTP_LOAD,
	output logic                    DISPLAY_BLANK,
	output logic                    CMD_READY
);
	dlr_pkg::dlr_ref_t  r;
	dlr_pkg::dlr_ref_t  n;
	dlr_pkg::dlr_link_t l;
	dlr_pkg::dlr_link_t m;
	logic               d0_chg;
	logic               ck_chg;
	logic               hold_ok;

	assign d0_chg  = r.d0_s != r.d0_q;
	assign ck_chg  = r.ck_s != r.ck_q;
	assign hold_ok = r.age >= 4'(`DLR_LP_CYC - 1);

	always_comb begin
		n = r;
		n.d0_m = D0_LP;
		n.d0_s = r.d0_m;
		n.d0_q = r.d0_s;
		n.ck_m = CLK_LP;
		n.ck_s = r.ck_m;
		n.ck_q = r.ck_s;
		n.rst_m = RESET_PIN_N;
		n.rst_s = r.rst_m;
		n.lp_err = 1'b0;
		n.lcnt = r.lcnt + 4'h1;
		// age of the present data-lane line state
		if (d0_chg)
			n.age = 4'h0;
		else if (r.age != `DLR_AGE_MAX)
			n.age = r.age + 4'h1;
		// data lane 0 sequencer
		unique case (r.lane)
			dlr_pkg::LN_STOP: begin
				if (d0_chg && r.d0_s == `DLR_LP01)
					n.lane = dlr_pkg::LN_RQST;
				else if (d0_chg && r.d0_s == `DLR_LP10)
					n.lane = dlr_pkg::LN_BTA1;
			end
			dlr_pkg::LN_RQST: begin
				if (d0_chg) begin
					if (r.d0_s == `DLR_LP00 && hold_ok) begin
						n.lane = dlr_pkg::LN_HS;
					end else begin
						n.lane = dlr_pkg::LN_STOP;
						n.lp_err = r.d0_s == `DLR_LP00;
					end
				end
			end
			dlr_pkg::LN_HS: begin
				if (d0_chg && r.d0_s == `DLR_LP11) begin
					n.lane = dlr_pkg::LN_SKIP;
					n.lcnt = 4'h0;
				end
			end
			dlr_pkg::LN_SKIP: begin
				if (r.lcnt == 4'(`DLR_SKIP_CYC - 1))
					n.lane = dlr_pkg::LN_STOP;
			end
			dlr_pkg::LN_BTA1: begin
				if (d0_chg)
					n.lane = (r.d0_s == `DLR_LP00) ? dlr_pkg::LN_BTA2 : dlr_pkg::LN_STOP;
			end
			dlr_pkg::LN_BTA2: begin
				if (d0_chg)
					n.lane = (r.d0_s == `DLR_LP10) ? dlr_pkg::LN_BTA3 : dlr_pkg::LN_STOP;
			end
			dlr_pkg::LN_BTA3: begin
				if (d0_chg && r.d0_s == `DLR_LP00) begin
					n.lane = dlr_pkg::LN_SURE;
					n.lcnt = 4'h0;
				end else if (d0_chg) begin
					n.lane = dlr_pkg::LN_STOP;
				end
			end
			dlr_pkg::LN_SURE: begin
				if (r.lcnt == 4'(`DLR_SURE_CYC - 1)) begin
					n.lane = dlr_pkg::LN_GET;
					n.lcnt = 4'h0;
				end
			end
			dlr_pkg::LN_GET: begin
				if (r.lcnt == 4'(`DLR_GET_CYC - 1)) begin
					n.lane = dlr_pkg::LN_OWN;
					n.lcnt = 4'h0;
				end
			end
			dlr_pkg::LN_OWN: begin
				if (r.lcnt == 4'(`DLR_LP_CYC - 1)) begin
					n.lane = dlr_pkg::LN_BK10;
					n.lcnt = 4'h0;
				end
			end
			dlr_pkg::LN_BK10: begin
				if (r.lcnt == 4'(`DLR_LP_CYC - 1)) begin
					n.lane = dlr_pkg::LN_BK00;
					n.lcnt = 4'h0;
				end
			end
			dlr_pkg::LN_BK00: begin
				if (r.lcnt == 4'(`DLR_LP_CYC - 1)) begin
					n.lane = dlr_pkg::LN_STOP;
					n.lcnt = 4'h0;
				end
			end
			default: n.lane = dlr_pkg::LN_STOP;
		endcase
		n.hs_open = n.lane == dlr_pkg::LN_HS;
		// clock lane sequencer
		unique case (r.ck)
			dlr_pkg::CK_STOP: begin
				if (ck_chg && r.ck_s == `DLR_LP01)
					n.ck = dlr_pkg::CK_RQST;
			end
			dlr_pkg::CK_RQST: begin
				if (ck_chg)
					n.ck = (r.ck_s == `DLR_LP00) ? dlr_pkg::CK_HS : dlr_pkg::CK_STOP;
			end
			dlr_pkg::CK_HS: begin
				if (ck_chg && r.ck_s == `DLR_LP11)
					n.ck = dlr_pkg::CK_STOP;
			end
			default: n.ck = dlr_pkg::CK_STOP;
		endcase
		// reset pin filter and completion sequence
		unique case (r.rs)
			dlr_pkg::RS_RUN: begin
				if (r.rst_s) begin
					n.rcnt = 23'h0;
				end else if (r.rcnt == 23'(`DLR_REJ_CYC - 1)) begin
					n.rs = dlr_pkg::RS_LOW;
					n.asleep = SLEEP_IN;
					n.full = 1'b0;
					n.hcnt = 9'h0;
					n.rcnt = r.rcnt + 23'h1;
				end else begin
					n.rcnt = r.rcnt + 23'h1;
				end
			end
			dlr_pkg::RS_LOW: begin
				if (!r.rst_s) begin
					n.hcnt = 9'h0;
					if (r.rcnt == 23'(`DLR_FULL_CYC - 1))
						n.full = 1'b1;
					if (r.rcnt != 23'(`DLR_FULL_CYC))
						n.rcnt = r.rcnt + 23'h1;
				end else if (r.hcnt == 9'(`DLR_REJ_CYC - 1)) begin
					n.rs = dlr_pkg::RS_OTP;
					n.rcnt = 23'(`DLR_REJ_CYC);
				end else begin
					n.hcnt = r.hcnt + 9'h1;
				end
			end
			dlr_pkg::RS_OTP: begin
				if (r.rcnt == 23'(OTP_CYC - 1)) begin
					n.rs = r.asleep ? dlr_pkg::RS_RUN : dlr_pkg::RS_BLANK;
					n.rcnt = r.asleep ? 23'h0 : r.rcnt + 23'h1;
				end else begin
					n.rcnt = r.rcnt + 23'h1;
				end
			end
			dlr_pkg::RS_BLANK: begin
				if (r.rcnt == 23'(BLANK_CYC - 1)) begin
					n.rs = dlr_pkg::RS_RUN;
					n.rcnt = 23'h0;
				end else begin
					n.rcnt = r.rcnt + 23'h1;
				end
			end
		endcase
	end

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET)
			r <= '0;
		else
			r <= n;
	end

	// link-side byte gate
	always_comb begin
		m = l;
		m.acc_m = r.hs_open;
		m.acc_s = l.acc_m;
		m.rx.valid = l.acc_s && HS_IN.valid;
		if (HS_IN.valid)
			m.rx.data = HS_IN.data;
	end

	always_ff @(posedge LINK_CLK or posedge RESET) begin
		if (RESET)
			l <= '0;
		else
			l <= m;
	end

	assign D0_LP_OE = r.lane inside {dlr_pkg::LN_GET, dlr_pkg::LN_OWN,
		dlr_pkg::LN_BK10, dlr_pkg::LN_BK00};
	assign D0_LP_OUT = (r.lane == dlr_pkg::LN_OWN) ? `DLR_LP11 :
		(r.lane == dlr_pkg::LN_BK10) ? `DLR_LP10 : `DLR_LP00;
	assign D0_TERM = r.lane == dlr_pkg::LN_HS;
	assign LP_ERR = r.lp_err;
	assign CLK_TERM = r.ck == dlr_pkg::CK_HS;
	assign RX_OUT = l.rx;
	assign CHIP_RESET = r.rs == dlr_pkg::RS_LOW;
	assign RESET_FULL = r.full;
	assign OTP_LOAD = r.rs == dlr_pkg::RS_OTP;
	assign DISPLAY_BLANK = r.rs != dlr_pkg::RS_RUN;
	assign CMD_READY = r.rs == dlr_pkg::RS_RUN;

	sure_wait_a: assert property (
		@(posedge REF_CLK) disable iff (RESET)
		$rose(r.lane == dlr_pkg::LN_SURE) |-> !D0_LP_OE [*3] ##1 D0_LP_OE)
		else $error("turnaround drive started at wrong time");

	get_hold_a: assert property (
		@(posedge REF_CLK) disable iff (RESET)
		$rose(r.lane == dlr_pkg::LN_GET) |->
			(D0_LP_OE && D0_LP_OUT == `DLR_LP00) [*8] ##1
			(D0_LP_OE && D0_LP_OUT == `DLR_LP00) [*2] ##1 D0_LP_OUT == `DLR_LP11)
		else $error("both-low takeover not held ten cycles");

	drive_len_a: assert property (
		@(posedge REF_CLK) disable iff (RESET)
		(D0_LP_OE && $changed(D0_LP_OUT)) |=> $stable(D0_LP_OUT) ##1
			($changed(D0_LP_OUT) || !D0_LP_OE || r.lane == dlr_pkg::LN_GET))
		else $error("driven line state not two cycles");

	term_fast_a: assert property (
		@(posedge REF_CLK) disable iff (RESET)
		(r.lane == dlr_pkg::LN_RQST && d0_chg && r.d0_s == `DLR_LP00)
			|=> (D0_TERM != LP_ERR))
		else $error("prepare not answered by termination or error");

	skip_len_a: assert property (
		@(posedge REF_CLK) disable iff (RESET)
		$rose(r.lane == dlr_pkg::LN_SKIP) |->
			(r.lane == dlr_pkg::LN_SKIP && !D0_TERM) [*2] ##1 r.lane == dlr_pkg::LN_STOP)
		else $error("end-of-burst ignore window wrong length");

	clk_term_a: assert property (
		@(posedge REF_CLK) disable iff (RESET)
		(r.ck == dlr_pkg::CK_RQST && ck_chg && r.ck_s == `DLR_LP00) |=> CLK_TERM)
		else $error("clock termination late");

	glitch_rej_a: assert property (
		@(posedge REF_CLK) disable iff (RESET)
		$rose(CHIP_RESET) |-> $past(r.rcnt) == 23'(`DLR_REJ_CYC - 1) && !$past(r.rst_s))
		else $error("reset accepted after wrong low width");

	full_rst_a: assert property (
		@(posedge REF_CLK) disable iff (RESET)
		$rose(RESET_FULL) |-> CHIP_RESET && r.rcnt == 23'(`DLR_FULL_CYC))
		else $error("full reset flagged at wrong width");

	otp_bound_a: assert property (
		@(posedge REF_CLK) disable iff (RESET)
		OTP_LOAD |-> DISPLAY_BLANK && r.rcnt < 23'(OTP_CYC))
		else $error("memory load overran its bound");

	sleep_done_a: assert property (
		@(posedge REF_CLK) disable iff (RESET)
		($fell(OTP_LOAD) && r.asleep) |-> CMD_READY && !DISPLAY_BLANK)
		else $error("asleep reset not done after load");

	blank_end_a: assert property (
		@(posedge REF_CLK) disable iff (RESET)
		$fell(DISPLAY_BLANK) |-> !r.asleep ? $past(r.rcnt) == 23'(BLANK_CYC - 1) : 1'b1)
		else $error("awake blanking ended at wrong time");

	rx_gate_a: assert property (
		@(posedge LINK_CLK) disable iff (RESET)
		RX_OUT.valid |-> $past(l.acc_s) && $past(HS_IN.valid))
		else $error("byte passed outside a burst");
endmodule
`default_nettype wire

// File: bench/dlr_host_model.sv
// host model driving the lanes, the byte strobe and the reset pin
`default_nettype none
module dlr_host_model (
	// clocks
	input  wire logic             clk,
	input  wire logic             link_clk,
	// lane 0 as seen on the wire
	input  wire logic             dut_oe,
	input  wire dlr_pkg::dlr_lp_t dut_out,
	output dlr_pkg::dlr_lp_t      line,
	// clock lane, bytes and reset pin
	output dlr_pkg::dlr_lp_t      ck,
	output dlr_pkg::dlr_byte_t    hs,
	output logic                  rst_n
);
	timeunit 1ns;
	timeprecision 1ps;
	dlr_pkg::dlr_lp_t d0;
	logic             d0_oe;
	// a released lane shows the inverse of its last level
	assign line = dut_oe ? dut_out : (d0_oe ? d0 : ~d0);
	initial begin
		d0 = 2'h3;
		d0_oe = 1'b1;
		ck = 2'h3;
		hs = '0;
		rst_n = 1'b1;
	end
	task d0_put(input logic [1:0] v, input int k);
		@(negedge clk);
		d0 = v;
		repeat (k - 1) @(negedge clk);
	endtask
	task ck_enter();
		@(negedge clk);
		ck = 2'h1;
		repeat (2) @(negedge clk);
		ck = 2'h0;
	endtask
	task ck_exit();
		@(negedge clk);
		ck = 2'h3;
	endtask
	task hs_enter();
		d0_put(2'h1, 2);
		@(negedge clk);
		d0 = 2'h0;
	endtask
	task hs_exit();
		@(negedge clk);
		d0 = 2'h3;
	endtask
	task send(input logic [7:0] b);
		@(negedge link_clk);
		hs = {1'b1, b};
		@(negedge link_clk);
		hs = '0;
	endtask
	task bta();
		d0_put(2'h2, 2);
		d0_put(2'h0, 2);
		d0_put(2'h2, 2);
		@(negedge clk);
		d0 = 2'h0;
		fork
			begin
				repeat (8) @(negedge clk);
				d0_oe = 1'b0;
			end
		join_none
	endtask
	task retake();
		@(negedge clk);
		d0 = 2'h3;
		d0_oe = 1'b1;
	endtask
	task pulse(input int k);
		@(negedge clk);
		rst_n = 1'b0;
		repeat (k) @(negedge clk);
		rst_n = 1'b1;
	endtask
endmodule
`default_nettype wire

// File: bench/dlr_top_tb.sv
// self-checking bench for the lane and reset sequencer
`default_nettype none
module dlr_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic               REF_CLK;
	logic               LINK_CLK;
	logic               RESET;
	logic               SLEEP_IN;
	logic               RESET_PIN_N;
	dlr_pkg::dlr_lp_t   D0_LP;
	dlr_pkg::dlr_lp_t   CLK_LP;
	dlr_pkg::dlr_lp_t   D0_LP_OUT;
	dlr_pkg::dlr_byte_t HS_IN;
	dlr_pkg::dlr_byte_t RX_OUT;
	logic               D0_LP_OE, D0_TERM, LP_ERR, CLK_TERM, CHIP_RESET;
	logic               RESET_FULL, OTP_LOAD, DISPLAY_BLANK, CMD_READY;
	logic [8:0]         mon;
	logic [7:0]         rx_last;
	int                 bad_count = 0;
	int                 checks = 0;
	int                 cyc = 0;
	int                 rx_cnt = 0;
	int                 n;
	assign mon = {LP_ERR, CMD_READY, DISPLAY_BLANK, OTP_LOAD, RESET_FULL, CHIP_RESET,
		CLK_TERM, D0_TERM, D0_LP_OE};
	dlr_top #(.OTP_CYC(300), .BLANK_CYC(600)) u_dlr_top (
		.REF_CLK(REF_CLK), .RESET(RESET), .LINK_CLK(LINK_CLK), .RESET_PIN_N(RESET_PIN_N),
		.SLEEP_IN(SLEEP_IN), .D0_LP(D0_LP), .D0_LP_OE(D0_LP_OE), .D0_LP_OUT(D0_LP_OUT),
		.D0_TERM(D0_TERM), .LP_ERR(LP_ERR), .CLK_LP(CLK_LP), .CLK_TERM(CLK_TERM),
		.HS_IN(HS_IN), .RX_OUT(RX_OUT), .CHIP_RESET(CHIP_RESET), .RESET_FULL(RESET_FULL),
		.OTP_LOAD(OTP_LOAD), .DISPLAY_BLANK(DISPLAY_BLANK), .CMD_READY(CMD_READY));
	dlr_host_model u_dlr_host_model (
		.clk(REF_CLK), .link_clk(LINK_CLK), .dut_oe(D0_LP_OE), .dut_out(D0_LP_OUT),
		.line(D0_LP), .ck(CLK_LP), .hs(HS_IN), .rst_n(RESET_PIN_N));
	initial begin
		REF_CLK = 1'b0;
		forever #12.5 REF_CLK = ~REF_CLK;
	end
	initial begin
		LINK_CLK = 1'b0;
		#7;
		forever #16 LINK_CLK = ~LINK_CLK;
	end
	always @(negedge LINK_CLK) begin
		if (RX_OUT.valid === 1'b1) begin
			rx_cnt <= rx_cnt + 1;
			rx_last <= RX_OUT.data;
		end
	end
	always @(posedge REF_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			bad_count++;
			summarize();
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task wait_lvl(input int idx, input logic lvl, input int lim, output int k);
		k = 0;
		while (mon[idx] !== lvl && k < lim) begin
			@(negedge REF_CLK);
			k++;
		end
	endtask
	task run_len(input logic [1:0] v, output int k);
		k = 0;
		while (D0_LP_OE === 1'b1 && D0_LP_OUT === v && k < 40) begin
			@(negedge REF_CLK);
			k++;
		end
	endtask
	task t_hs();
		u_dlr_host_model.ck_enter();
		wait_lvl(2, 1'b1, 10, n);
		chk(n <= 4, 1'b1);
		repeat (12) @(negedge REF_CLK);
		u_dlr_host_model.hs_enter();
		wait_lvl(1, 1'b1, 10, n);
		chk(n <= 4 && D0_TERM === 1'b1, 1'b1);
		repeat (4) @(negedge LINK_CLK);
		u_dlr_host_model.send(8'hA5);
		u_dlr_host_model.send(8'h3C);
		u_dlr_host_model.send(8'hC3);
		repeat (3) @(negedge LINK_CLK);
		chk(rx_cnt, 3);
		chk(rx_last, 8'hC3);
		u_dlr_host_model.hs_exit();
		wait_lvl(1, 1'b0, 10, n);
		chk(n <= 4 && D0_TERM === 1'b0, 1'b1);
		repeat (4) @(negedge LINK_CLK);
		u_dlr_host_model.send(8'h5A);
		repeat (3) @(negedge LINK_CLK);
		chk(rx_cnt, 3);
		u_dlr_host_model.ck_exit();
		wait_lvl(2, 1'b0, 10, n);
		chk(CLK_TERM, 1'b0);
	endtask
	task t_abort();
		u_dlr_host_model.d0_put(2'h1, 1);
		u_dlr_host_model.d0_put(2'h0, 1);
		wait_lvl(8, 1'b1, 8, n);
		chk(LP_ERR, 1'b1);
		repeat (3) @(negedge REF_CLK);
		chk(D0_TERM, 1'b0);
		u_dlr_host_model.d0_put(2'h3, 6);
		u_dlr_host_model.d0_put(2'h1, 2);
		u_dlr_host_model.d0_put(2'h3, 4);
		wait_lvl(8, 1'b1, 8, n);
		chk(n, 8);
		chk(D0_TERM, 1'b0);
		u_dlr_host_model.d0_put(2'h2, 2);
		u_dlr_host_model.d0_put(2'h3, 2);
		wait_lvl(0, 1'b1, 12, n);
		chk(n, 12);
	endtask
	task t_bta();
		u_dlr_host_model.bta();
		wait_lvl(0, 1'b1, 20, n);
		chk(n >= 4 && n <= 8, 1'b1);
		run_len(2'h0, n);
		chk(n >= 10, 1'b1);
		chk(D0_LP_OUT, 2'h3);
		run_len(2'h3, n);
		chk(n >= 2 && n <= 3, 1'b1);
		chk(D0_LP_OUT, 2'h2);
		run_len(2'h2, n);
		chk(n >= 2 && n <= 3, 1'b1);
		wait_lvl(0, 1'b0, 10, n);
		chk(n >= 2 && n <= 3, 1'b1);
		u_dlr_host_model.retake();
	endtask
	task t_pin();
		u_dlr_host_model.pulse(100);
		wait_lvl(3, 1'b1, 300, n);
		chk(n, 300);
		SLEEP_IN = 1'b1;
		u_dlr_host_model.pulse(450);
		chk(mon[7:3], 5'h0B);
		wait_lvl(5, 1'b1, 300, n);
		chk(n >= 200 && n <= 204, 1'b1);
		wait_lvl(5, 1'b0, 400, n);
		chk(n >= 99 && n <= 101, 1'b1);
		chk(mon[7:6], 2'h2);
		SLEEP_IN = 1'b0;
		u_dlr_host_model.pulse(250);
		chk(mon[7:3], 5'h09);
		wait_lvl(7, 1'b1, 1000, n);
		chk(n >= 590 && n <= 610, 1'b1);
		chk(DISPLAY_BLANK, 1'b0);
	endtask
	task t_spike();
		u_dlr_host_model.pulse(250);
		repeat (50) @(negedge REF_CLK);
		u_dlr_host_model.pulse(100);
		chk(mon[7:3], 5'h09);
		wait_lvl(5, 1'b1, 300, n);
		chk(n >= 200 && n <= 204, 1'b1);
		wait_lvl(7, 1'b1, 1000, n);
		chk(n >= 398 && n <= 402, 1'b1);
		chk(DISPLAY_BLANK, 1'b0);
	endtask
	task summarize();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		RESET = 1'b1;
		SLEEP_IN = 1'b0;
		repeat (2) @(negedge REF_CLK);
		RESET = 1'b0;
		chk(mon, 9'h080);
		chk(RX_OUT, 9'h000);
		repeat (4) @(negedge REF_CLK);
		t_hs();
		t_abort();
		t_bta();
		t_pin();
		t_spike();
		summarize();
	end
endmodule
`default_nettype wire
